// >>> legacy_regs_pkg.sv
// Port addresses, field positions and reset values of the legacy general registers
package legacy_regs_pkg;

  // Byte ports as seen on the host I/O bus
  localparam logic [15:0] PORT_STAT_MONO = 16'h03BA;  // Status read / feature write, mono range
  localparam logic [15:0] PORT_STAT_COLR = 16'h03DA;  // Status read / feature write, colour range
  localparam logic [15:0] PORT_FEAT_RD   = 16'h03CA;  // Feature control readback
  localparam logic [15:0] PORT_MISC_WR   = 16'h03C2;  // Misc output write
  localparam logic [15:0] PORT_MISC_RD   = 16'h03CC;  // Misc output readback
  localparam logic [15:0] PORT_SEQ_IDX   = 16'h03C4;  // Sequencer index

  // Shared widths
  localparam int unsigned REG_W  = 8;
  localparam int unsigned IO_W   = 16;
  localparam int unsigned WORD_W = 15;
  localparam int unsigned IDX_W  = 3;

  // Reset value of every register
  localparam logic [7:0] REG_RST = 8'h00;

  // Retrace status fields
  localparam int unsigned ST_DE_BIT = 0;
  localparam int unsigned ST_VR_BIT = 3;
  localparam int unsigned ST_FB_LO  = 4;
  localparam int unsigned ST_FB_HI  = 5;
  localparam logic [7:0]  ST_MASK   = 8'h39;

  // Feature control fields
  localparam int unsigned FC_SYNC_BIT = 3;
  localparam logic [7:0]  FC_MASK     = 8'h08;

  // Misc output fields
  localparam int unsigned MO_VPOL_BIT = 7;
  localparam int unsigned MO_HPOL_BIT = 6;
  localparam int unsigned MO_PAGE_BIT = 5;
  localparam int unsigned MO_CLK_HI   = 3;
  localparam int unsigned MO_CLK_LO   = 2;
  localparam int unsigned MO_APER_BIT = 1;
  localparam int unsigned MO_IOSEL_BIT = 0;
  localparam logic [7:0]  MO_MASK     = 8'hEF;

  // Dot clock select codes
  localparam logic [1:0] CLK_SEL_FIRST  = 2'h0;
  localparam logic [1:0] CLK_SEL_SECOND = 2'h1;

  // Sequencer index mask
  localparam logic [7:0] IDX_MASK = 8'h07;

  // Picks the two palette colour bits fed back to status bits 5:4
  function automatic logic [1:0] fb_pick(input logic [1:0] sel, input logic [7:0] pal);
    case (sel)
      2'h0:    fb_pick = {pal[2], pal[0]};
      2'h1:    fb_pick = {pal[5], pal[4]};
      2'h2:    fb_pick = {pal[3], pal[1]};
      default: fb_pick = {pal[7], pal[6]};
    endcase
  endfunction : fb_pick

endpackage : legacy_regs_pkg

// >>> regs_link_if.sv
// Carrier between the register core, its port decoder and its status sampler
`timescale 1ns/100ps
interface regs_link_if;
  logic [14:0] port_word;   // Host word address, bits 15:1
  logic        lane_lo;     // Low byte lane taking part
  logic        colour_io;   // Colour range selected
  logic        hit_stat;    // Status read / feature write port
  logic        hit_feat_rd; // Feature readback port
  logic        hit_misc_wr; // Misc write port
  logic        hit_misc_rd; // Misc readback port
  logic        hit_idx;     // Sequencer index port
  logic [7:0]  status;      // Assembled retrace status byte

  modport core (output port_word, lane_lo, colour_io,
                input  hit_stat, hit_feat_rd, hit_misc_wr, hit_misc_rd, hit_idx, status);
  modport dec  (input  port_word, lane_lo, colour_io,
                output hit_stat, hit_feat_rd, hit_misc_wr, hit_misc_rd, hit_idx);
  modport stat (output status);
endinterface : regs_link_if

// >>> io_port_decoder.sv
// Combinational decode of host I/O ports onto the general registers
`timescale 1ns/100ps
module io_port_decoder
  import legacy_regs_pkg::*;
#(
  parameter bit CLAIM_BOTH = 1'b0
) (
  regs_link_if.dec lnk
);

  logic [15:0] active_port;
  logic [15:0] other_port;

  // Status read / feature write port follows the emulation mode
  assign active_port = lnk.colour_io ? PORT_STAT_COLR : PORT_STAT_MONO;
  assign other_port  = lnk.colour_io ? PORT_STAT_MONO : PORT_STAT_COLR;

  // Optional claim of both ranges; strict by default
  assign lnk.hit_stat = lnk.lane_lo && ((lnk.port_word == active_port[15:1]) ||
                        (CLAIM_BOTH && (lnk.port_word == other_port[15:1])));

  // Fixed ports
  assign lnk.hit_feat_rd = lnk.lane_lo && (lnk.port_word == PORT_FEAT_RD[15:1]);
  assign lnk.hit_misc_wr = lnk.lane_lo && (lnk.port_word == PORT_MISC_WR[15:1]);
  assign lnk.hit_misc_rd = lnk.lane_lo && (lnk.port_word == PORT_MISC_RD[15:1]);
  assign lnk.hit_idx     = lnk.lane_lo && (lnk.port_word == PORT_SEQ_IDX[15:1]);

endmodule : io_port_decoder

// >>> timing_status_sampler.sv
// Synchronises display timing and palette bits and builds the status byte
`timescale 1ns/100ps
module timing_status_sampler
  import legacy_regs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       legacy_off,
  input  wire logic [2:0] legacy_timing,
  input  wire logic [2:0] pipe_timing,
  input  wire logic [7:0] palette_bits,
  input  wire logic [1:0] plane_pair,
  regs_link_if.stat       lnk
);

  localparam int unsigned SYNC_W = 17;

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic [2:0]        tim;
  logic [7:0]        status_ff;
  logic [7:0]        nxt_status;

  assign raw = {legacy_off, legacy_timing, pipe_timing, palette_bits, plane_pair};

  // Two-stage synchroniser per input bit
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end else if (clk_en) begin
        meta_ff[i] <= raw[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  // Timing source: legacy generator, or the assigned pipe when legacy is off
  assign tim = sync_ff[16] ? sync_ff[12:10] : sync_ff[15:13];

  // Status byte; timing order is {vretrace, vblank, hblank}
  always_comb begin
    nxt_status                      = REG_RST;
    nxt_status[ST_FB_HI:ST_FB_LO]   = fb_pick(sync_ff[1:0], sync_ff[9:2]);
    nxt_status[ST_VR_BIT]           = tim[2];
    nxt_status[ST_DE_BIT]           = tim[1] | tim[0];
  end

  // Registered status
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= REG_RST;
    end else if (clk_en) begin
      status_ff <= nxt_status;
    end
  end

  assign lnk.status = status_ff;

endmodule : timing_status_sampler

// >>> legacy_general_regs.sv
// Legacy display general registers: retrace status, feature control, misc output, sequencer index
//
// Notes on behaviour
// - Retrace status decodes at mono or colour port chosen by misc output mode.
// - Status reads return zero in bits 7:6 and 2:1.
// - Feedback bits mirror two palette colour bits chosen by plane-enable bits.
// - Vertical retrace bit reads 1 during vertical retrace, else 0.
// - Retrace may come from internal legacy timing, loosely tied to output sync.
// - With legacy plane off, status follows the assigned pipe's timing.
// - No interrupt on vertical retrace; status is polled only.
// - Display-enable bit reads 0 in active video, 1 in any blanking.
// - Feature control written at mode port, read back at fixed port.
// - Feature sync-select bit is pure storage, affecting nothing else.
// - All other feature control bits read zero whatever is written.
// - Misc output written at one fixed port, read at another.
// - Misc bits 7 and 6 set vertical and horizontal sync polarity.
// - Page select picks 64 KB page in odd/even mode: 0 upper, 1 lower.
// - Two-bit clock select picks native dot clock; 10 unused, 11 reserved.
// - Memory enable gates legacy aperture only, never the linear frame buffer.
// - Address select puts status, feature and CRT ports in mono or colour range.
// - Both port ranges may be claimed regardless of address select.
// - Sequencer index holds three bits; upper bits read zero.
`timescale 1ns/100ps
module legacy_general_regs
  import legacy_regs_pkg::*;
#(
  parameter bit CLAIM_BOTH = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [15:0] io_addr,
  input  wire logic [1:0]  io_be,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [15:0] io_wdata,
  output logic      [15:0] io_rdata,
  output logic             io_ack,
  output logic             io_claim,
  input  wire logic        legacy_off,
  input  wire logic [2:0]  legacy_timing,
  input  wire logic [2:0]  pipe_timing,
  input  wire logic [7:0]  palette_bits,
  input  wire logic [1:0]  plane_pair,
  input  wire logic        aper_req,
  input  wire logic        aper_legacy,
  output logic             aper_grant,
  output logic             aper_deny,
  output logic             vsync_neg,
  output logic             hsync_neg,
  output logic             page_lower,
  output logic      [1:0]  dot_clk_sel,
  output logic             dot_clk_native,
  output logic             aperture_en,
  output logic             colour_io,
  output logic             feature_sync_sel,
  output logic      [2:0]  sequencer_index
);

  regs_link_if lnk ();

  logic [7:0]  feature_ff;
  logic [7:0]  misc_ff;
  logic [7:0]  index_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        ack_ff;
  logic        claim_ff;
  logic        nxt_claim;
  logic        grant_ff;
  logic        deny_ff;
  logic        clk_native_ff;
  logic        wr_feat;
  logic        wr_misc;
  logic        wr_idx;
  logic [7:0]  wbyte;

  // Address and mode toward the decoder
  assign lnk.port_word = io_addr[15:1];
  assign lnk.lane_lo   = io_be[0];
  assign lnk.colour_io = misc_ff[MO_IOSEL_BIT];

  io_port_decoder #(
    .CLAIM_BOTH (CLAIM_BOTH)
  ) u_dec (
    .lnk (lnk)
  );

  timing_status_sampler u_stat (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .clk_en        (clk_en),
    .legacy_off    (legacy_off),
    .legacy_timing (legacy_timing),
    .pipe_timing   (pipe_timing),
    .palette_bits  (palette_bits),
    .plane_pair    (plane_pair),
    .lnk           (lnk)
  );

  // Write strobes; only the low lane carries a mapped port
  assign wbyte   = io_wdata[7:0];
  assign wr_feat = io_wr && lnk.hit_stat;
  assign wr_misc = io_wr && lnk.hit_misc_wr;
  assign wr_idx  = io_wr && lnk.hit_idx;

  // Feature control: only the sync-select bit is kept
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      feature_ff <= REG_RST;
    end else if (clk_en && wr_feat) begin
      feature_ff <= wbyte & FC_MASK;
    end
  end

  // Misc output; reserved bit 4 is dropped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      misc_ff <= REG_RST;
    end else if (clk_en && wr_misc) begin
      misc_ff <= wbyte & MO_MASK;
    end
  end

  // Sequencer index, three bits wide
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      index_ff <= REG_RST;
    end else if (clk_en && wr_idx) begin
      index_ff <= wbyte & IDX_MASK;
    end
  end

  // Read mux; upper lane never maps a register and reads zero
  always_comb begin
    nxt_rdata = {8'h00, REG_RST};
    nxt_claim = 1'b0;
    if (io_rd && lnk.hit_stat) begin
      nxt_rdata[7:0] = lnk.status & ST_MASK;
      nxt_claim      = 1'b1;
    end else if (io_rd && lnk.hit_feat_rd) begin
      nxt_rdata[7:0] = feature_ff;
      nxt_claim      = 1'b1;
    end else if (io_rd && lnk.hit_misc_rd) begin
      nxt_rdata[7:0] = misc_ff;
      nxt_claim      = 1'b1;
    end else if (io_rd && lnk.hit_idx) begin
      nxt_rdata[7:0] = index_ff;
      nxt_claim      = 1'b1;
    end else if (wr_feat || wr_misc || wr_idx) begin
      nxt_claim      = 1'b1;
    end
  end

  // Registered bus answer, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 16'h0000;
      ack_ff   <= 1'b0;
      claim_ff <= 1'b0;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
      ack_ff   <= io_rd || io_wr;
      claim_ff <= nxt_claim;
    end
  end

  // Aperture gate: legacy window follows the enable, linear buffer always passes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grant_ff <= 1'b0;
      deny_ff  <= 1'b0;
    end else if (clk_en) begin
      grant_ff <= aper_req && (!aper_legacy || misc_ff[MO_APER_BIT]);
      deny_ff  <= aper_req && aper_legacy && !misc_ff[MO_APER_BIT];
    end
  end

  // Native clock flag: only the two defined codes pick a real clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_native_ff <= 1'b1;
    end else if (clk_en) begin
      clk_native_ff <= (misc_ff[MO_CLK_HI:MO_CLK_LO] == CLK_SEL_FIRST) ||
                       (misc_ff[MO_CLK_HI:MO_CLK_LO] == CLK_SEL_SECOND);
    end
  end

  // Outputs straight from register bits; no interrupt output exists
  assign io_rdata         = rdata_ff;
  assign io_ack           = ack_ff;
  assign io_claim         = claim_ff;
  assign aper_grant       = grant_ff;
  assign aper_deny        = deny_ff;
  assign vsync_neg        = misc_ff[MO_VPOL_BIT];
  assign hsync_neg        = misc_ff[MO_HPOL_BIT];
  assign page_lower       = misc_ff[MO_PAGE_BIT];
  assign dot_clk_sel      = misc_ff[MO_CLK_HI:MO_CLK_LO];
  assign dot_clk_native   = clk_native_ff;
  assign aperture_en      = misc_ff[MO_APER_BIT];
  assign colour_io        = misc_ff[MO_IOSEL_BIT];
  assign feature_sync_sel = feature_ff[FC_SYNC_BIT];
  assign sequencer_index  = index_ff[IDX_W-1:0];

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  stat_reserved_a: assert property ((clk_en && io_rd && lnk.hit_stat) |=> (io_rdata[7:0] & ~ST_MASK) == 8'h00)
    else $error("status reserved bits not zero");

  stat_decode_a: assert property ((clk_en && io_rd && io_be[0] && !CLAIM_BOTH &&
      (io_addr[15:1] == (misc_ff[MO_IOSEL_BIT] ? PORT_STAT_MONO[15:1] : PORT_STAT_COLR[15:1]))) |=> !io_claim)
    else $error("inactive status port claimed");

  stat_vret_a: assert property ((clk_en && io_rd && lnk.hit_stat) |=> io_rdata[ST_VR_BIT] == $past(lnk.status[ST_VR_BIT]))
    else $error("retrace bit not the sampled status");

  stat_de_a: assert property ((clk_en && io_rd && lnk.hit_stat) |=> io_rdata[ST_DE_BIT] == $past(lnk.status[ST_DE_BIT]))
    else $error("display enable bit not the sampled status");

  feat_store_a: assert property ((clk_en && wr_feat) ##1 (clk_en && io_rd && lnk.hit_feat_rd && !io_wr) |=>
      io_rdata[7:0] == ($past(io_wdata[7:0], 2) & FC_MASK))
    else $error("feature readback differs from write");

  feat_zero_a: assert property ((feature_ff & ~FC_MASK) == 8'h00)
    else $error("feature reserved bit set");

  misc_store_a: assert property ((clk_en && wr_misc) |=> misc_ff == ($past(io_wdata[7:0]) & MO_MASK))
    else $error("misc output not stored");

  idx_upper_a: assert property ((clk_en && wr_idx) |=> (index_ff[7:IDX_W] == 5'h00) &&
      (sequencer_index == $past(io_wdata[IDX_W-1:0])))
    else $error("sequencer index wrong");

  aper_gate_a: assert property ((clk_en && aper_req && !aper_legacy) |=> aper_grant && !aper_deny)
    else $error("linear buffer access blocked");

  polarity_a: assert property ((clk_en && wr_misc) |=> vsync_neg == $past(io_wdata[MO_VPOL_BIT]) &&
      hsync_neg == $past(io_wdata[MO_HPOL_BIT]))
    else $error("sync polarity not taken from write");

  // Main scenarios
  cov_stat_rd_c:   cover property (clk_en && io_rd && lnk.hit_stat);
  cov_colour_c:    cover property (clk_en && wr_misc && io_wdata[MO_IOSEL_BIT]);
  cov_aper_deny_c: cover property (aper_deny);
  cov_pipe_src_c:  cover property (legacy_off && clk_en && io_rd && lnk.hit_stat);

endmodule : legacy_general_regs

// >>> host_io_model.sv
// Host processor model issuing byte and word I/O port cycles
`timescale 1ns/100ps
module host_io_model (
  input  wire logic        sys_clk,
  output logic      [15:0] io_addr,
  output logic      [1:0]  io_be,
  output logic             io_rd,
  output logic             io_wr,
  output logic      [15:0] io_wdata
);
  // Bus idle at time zero
  initial begin
    io_addr  = 16'h0000;
    io_be    = 2'h0;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_wdata = 16'h0000;
  end

  // One cycle strobe; afterwards the released bus shows the inverse pattern
  task automatic access(input logic wr, input logic [15:0] addr, input logic [1:0] be, input logic [15:0] wdata);
    @(negedge sys_clk);
    io_addr  = {addr[15:1], 1'b0};  // Even address, byte or word only
    io_be    = be;
    io_wdata = wdata;
    io_rd    = ~wr;
    io_wr    = wr;
    @(negedge sys_clk);
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_addr  = ~io_addr;
    io_be    = ~io_be;
    io_wdata = ~io_wdata;
  endtask : access
endmodule : host_io_model

// >>> legacy_general_regs_test.sv
// Self-checking bench for the legacy general registers
`timescale 1ns/100ps
module legacy_general_regs_test;
  import legacy_regs_pkg::*;
  logic        sys_clk, arst_n, clk_en, legacy_off, aper_req, aper_legacy;
  logic [15:0] io_addr, io_wdata, io_rdata;
  logic [1:0]  io_be, plane_pair, dot_clk_sel, fb;
  logic        io_rd, io_wr, io_ack, io_claim, aper_grant, aper_deny;
  logic [2:0]  legacy_timing, pipe_timing, sequencer_index, t;
  logic [7:0]  palette_bits, mo, f;
  logic        vsync_neg, hsync_neg, page_lower, dot_clk_native, aperture_en, colour_io, feature_sync_sel;
  logic [16:0] io_q[$];
  logic [1:0]  ap_q[$];
  int          mismatches, n_compared, i;
  integer      seed = 32'h7bf0;

  host_io_model host_io_model_inst (.sys_clk(sys_clk), .io_addr(io_addr), .io_be(io_be), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata));

  legacy_general_regs legacy_general_regs_inst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .io_addr(io_addr), .io_be(io_be), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_ack(io_ack), .io_claim(io_claim), .legacy_off(legacy_off), .legacy_timing(legacy_timing),
    .pipe_timing(pipe_timing), .palette_bits(palette_bits), .plane_pair(plane_pair), .aper_req(aper_req),
    .aper_legacy(aper_legacy), .aper_grant(aper_grant), .aper_deny(aper_deny), .vsync_neg(vsync_neg),
    .hsync_neg(hsync_neg), .page_lower(page_lower), .dot_clk_sel(dot_clk_sel),
    .dot_clk_native(dot_clk_native), .aperture_en(aperture_en), .colour_io(colour_io),
    .feature_sync_sel(feature_sync_sel), .sequencer_index(sequencer_index));

  // 50 MHz clock
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  task automatic cmp_out(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_out

  task automatic cmp_bus(input logic [16:0] exp);
    cmp_out("io answer", exp, {io_claim, io_rdata});
  endtask : cmp_bus

  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // Read with expected claim and byte
  task automatic rd(input logic [15:0] a, input logic [1:0] be, input logic c, input logic [7:0] d);
    io_q.push_back({c, 8'h00, d});
    host_io_model_inst.access(1'b0, a, be, 16'h0000);
  endtask : rd

  // Write with expected claim; upper lane carries noise
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic c);
    io_q.push_back({c, 16'h0000});
    host_io_model_inst.access(1'b1, a, 2'h3, {8'($random(seed)), d});
  endtask : wr

  // Memory request, grant expected for linear buffer or enabled aperture
  task automatic aper(input logic leg);
    @(negedge sys_clk);
    aper_req    = 1'b1;
    aper_legacy = leg;
    ap_q.push_back((~leg | mo[1]) ? 2'h2 : 2'h1);
    @(negedge sys_clk);
    aper_req    = 1'b0;
    aper_legacy = ~leg;
  endtask : aper

  // Bounded wait for all pending answers
  task automatic drain;
    int n;
    n = 0;
    while ((io_q.size() + ap_q.size()) != 0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    #2;
    if ((io_q.size() + ap_q.size()) != 0) begin
      cmp_out("pending answers", 17'h00000, 17'(io_q.size() + ap_q.size()));
      complete_run();
    end
  endtask : drain

  // Watcher: every answer pops the oldest note
  always @(posedge sys_clk) begin
    #1;
    if (io_ack === 1'b1) begin
      if (io_q.size() == 0) cmp_out("io_ack", 17'h00000, 17'h00001);
      else cmp_bus(io_q.pop_front());
    end
    if ((aper_grant | aper_deny) === 1'b1) begin
      if (ap_q.size() == 0) cmp_out("aperture answer", 17'h00000, {aper_grant, aper_deny});
      else cmp_out("aperture answer", ap_q.pop_front(), {aper_grant, aper_deny});
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    cmp_out("watchdog", 17'h00000, 17'h00001);
    complete_run();
  end

  // Main sequence
  initial begin
    {arst_n, aper_req, aper_legacy, legacy_off, plane_pair, mo} = '0;
    clk_en = 1'b1;
    {legacy_timing, pipe_timing, palette_bits} = '0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    cmp_out("reset outputs", 17'h00001, {vsync_neg, hsync_neg, page_lower, dot_clk_sel, aperture_en,
      colour_io, feature_sync_sel, sequencer_index, dot_clk_native});
    rd(PORT_MISC_RD, 2'h3, 1'b1, 8'h00);
    rd(PORT_FEAT_RD, 2'h1, 1'b1, 8'h00);
    rd(PORT_SEQ_IDX, 2'h1, 1'b1, 8'h00);
    // Every clock code, both I/O ranges, aperture on and off
    for (i = 0; i < 4; i++) begin
      mo = 8'($random(seed));
      mo[3:2] = 2'(i);
      mo[0] = i[0];
      mo[1] = i[1];
      wr(PORT_MISC_WR, mo, 1'b1);
      rd(PORT_MISC_RD, 2'h1, 1'b1, mo & MO_MASK);
      drain();
      cmp_out("misc fields", {mo[7:5], mo[3:0]}, {vsync_neg, hsync_neg, page_lower, dot_clk_sel, aperture_en,
        colour_io});
      cmp_out("dot_clk_native", 17'(i < 2), dot_clk_native);
      f = 8'($random(seed));
      wr(mo[0] ? PORT_STAT_COLR : PORT_STAT_MONO, f, 1'b1);
      wr(mo[0] ? PORT_STAT_MONO : PORT_STAT_COLR, ~f, 1'b0);
      rd(PORT_FEAT_RD, 2'h1, 1'b1, f & FC_MASK);
      wr(PORT_SEQ_IDX, f, 1'b1);
      rd(PORT_SEQ_IDX, 2'h3, 1'b1, f & IDX_MASK);
      aper(1'b1);
      aper(1'b0);
      drain();
      cmp_out("feature_sync_sel", 17'(f[3]), feature_sync_sel);
      cmp_out("sequencer_index", 17'(f[2:0]), sequencer_index);
    end
    // Status from either timing source, every feedback pair, both ranges
    for (i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      legacy_off = i[2];
      plane_pair = i[1:0];
      legacy_timing = 3'($random(seed));
      pipe_timing = ~legacy_timing;
      palette_bits = 8'($random(seed));
      mo[0] = i[3];
      wr(PORT_MISC_WR, mo, 1'b1);
      repeat (4) @(negedge sys_clk);
      t = legacy_off ? pipe_timing : legacy_timing;
      case (plane_pair)
        2'h0: fb = {palette_bits[2], palette_bits[0]};
        2'h1: fb = {palette_bits[5], palette_bits[4]};
        2'h2: fb = {palette_bits[3], palette_bits[1]};
        default: fb = {palette_bits[7], palette_bits[6]};
      endcase
      rd(mo[0] ? PORT_STAT_COLR : PORT_STAT_MONO, 2'h1, 1'b1,
        {2'h0, fb, t[2], 2'h0, t[1] | t[0]});
      rd(mo[0] ? PORT_STAT_MONO : PORT_STAT_COLR, 2'h1, 1'b0, 8'h00);
    end
    // Refused cycles leave state alone
    rd(16'h03C0, 2'h1, 1'b0, 8'h00);
    rd(PORT_MISC_RD, 2'h2, 1'b0, 8'h00);
    wr(PORT_MISC_RD, 8'hFF, 1'b0);
    wr(PORT_FEAT_RD, 8'hFF, 1'b0);
    rd(PORT_MISC_RD, 2'h1, 1'b1, mo & MO_MASK);
    rd(PORT_FEAT_RD, 2'h1, 1'b1, f & FC_MASK);
    drain();
    complete_run();
  end
endmodule : legacy_general_regs_test
